// ===== hw/uart_ctl_pkg.sv
// Contract
// - Control register two at offset 3h, readable and writable at any time.
// - Transmit-empty enable bit 7 routes tx_buffer_empty_flag onto the interrupt.
// - Transmit-done enable bit 6 routes tx_done_flag onto the interrupt.
// - Receive-full enable bit 5 routes rx_buffer_full_flag onto the interrupt.
// - Line-quiet enable bit 4 routes the idle-line flag onto the interrupt.
// - Transmitter starts buffered data only with transmitter_on bit 3 set; it drives the pin.
// - In single-wire mode the direction bit decides transmit pin direction.
// - Clearing then setting transmitter_on during activity queues one idle character.
// - After transmitter_on clears, pin stays driven until queued work finishes.
// - Receive pin is released when rx_on is 0 or loopback is set.
// - Writing rx_standby 1 parks the receiver until idle or address-mark wakeup.
// - Hardware clears rx_standby when the selected wakeup condition appears.
// - Writing break_request 1 then 0 queues one break character.
// - Held break_request keeps queuing zero breaks, 10/11 or 13/14 bits long.
// - One or two breaks may be sent for a short break_request pulse.
// - Loopback routes transmitter output to the receiver, receive pin unused.
// - Loopback plus rx source select joins transmit pin to both directions.
// - tx_buffer_empty_flag is set at reset and when data moves to the shifter.
package uart_ctl_pkg;
    // Register offsets
    localparam logic [2:0] MODE_OFS = 3'h0;
    localparam logic [2:0] CTRL2_OFS = 3'h3;
    localparam logic [2:0] STATUS_OFS = 3'h4;
    localparam logic [2:0] DATA_OFS = 3'h7;
    // Control register two fields
    localparam int TX_EMPTY_IRQ_EN_BIT = 7;
    localparam int TX_DONE_IRQ_EN_BIT = 6;
    localparam int RX_FULL_IRQ_EN_BIT = 5;
    localparam int LINE_QUIET_IRQ_EN_BIT = 4;
    localparam int TRANSMITTER_ON_BIT = 3;
    localparam int RX_ON_BIT = 2;
    localparam int RX_STANDBY_BIT = 1;
    localparam int BREAK_REQUEST_BIT = 0;
    localparam logic [7:0] CTRL2_RESET = 8'h00;
    // Mode register fields
    localparam int LONG_BREAK_BIT = 0;
    localparam int NINE_BIT_BIT = 1;
    localparam int WAKE_METHOD_BIT = 2;
    localparam int LOOPBACK_BIT = 3;
    localparam int RX_SOURCE_BIT = 4;
    localparam int DIRECTION_BIT = 5;
    localparam int TX_NINTH_BIT = 6;
    localparam logic [7:0] MODE_RESET = 8'h00;
    // Status register fields
    localparam int ST_TX_EMPTY_BIT = 7;
    localparam int ST_TX_DONE_BIT = 6;
    localparam int ST_RX_FULL_BIT = 5;
    localparam int ST_LINE_QUIET_BIT = 4;
    // Frame lengths in bit times
    localparam logic [3:0] FRAME_LEN_8 = 4'ha;
    localparam logic [3:0] FRAME_LEN_9 = 4'hb;
    localparam logic [3:0] LONG_BREAK_EXTRA = 4'h3;
endpackage

// ===== hw/tx_frame_shifter.sv
`timescale 1ns/1ps
`default_nettype none
module tx_frame_shifter (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // Bit timing
    input wire logic i_bit_tick,
    // Frame load
    input wire logic i_load,
    input wire logic [14:0] i_frame,
    input wire logic [3:0] i_len,
    // Line side
    output logic o_busy,
    output logic o_serial
);
    logic [14:0] shift_reg;
    logic [3:0] count_reg;
    logic serial_reg;

    // A load restarts the frame even mid-tick; the first bit may be short
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            shift_reg <= 15'h7fff;
            count_reg <= 4'h0;
            serial_reg <= 1'b1;
        end else if (i_load) begin
            shift_reg <= i_frame;
            count_reg <= i_len;
            serial_reg <= i_frame[0];
        end else if (i_bit_tick && count_reg != 4'h0) begin
            shift_reg <= {1'b1, shift_reg[14:1]};
            count_reg <= count_reg - 4'h1;
            serial_reg <= (count_reg == 4'h1) ? 1'b1 : shift_reg[1];
        end
    end

    assign o_busy = (count_reg != 4'h0);
    assign o_serial = serial_reg;
endmodule
`default_nettype wire

// ===== hw/uart_control_two_logic.sv
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module uart_control_two_logic (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // Register port
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Baud generator and receiver side
    input wire logic i_bit_tick,
    input wire logic i_rx_full_flag,
    input wire logic i_line_quiet_flag,
    input wire logic i_rx_idle_detect,
    input wire logic i_rx_char_done,
    input wire logic i_rx_msb,
    // Transmit pin
    input wire logic i_txd_pin,
    output logic o_txd_out,
    output logic o_txd_oe,
    // Receive pin and receiver input
    input wire logic i_rxd_pin,
    output logic o_rxd_owned,
    output logic o_rx_serial,
    output logic o_rx_standby,
    // Interrupt request
    output logic o_irq
);
    logic [7:0] ctrl2_reg;
    logic [7:0] ctrl2_next;
    logic [7:0] mode_reg;
    logic [8:0] txbuf_reg;
    logic tx_empty_reg;
    logic break_pending_reg;
    logic idle_pending_reg;
    logic [7:0] rdata_reg;
    logic rx_serial_reg;
    logic txd_meta_reg;
    logic txd_sync_reg;
    logic rxd_meta_reg;
    logic rxd_sync_reg;

    // Frame length for the current character format
    function automatic logic [3:0] frame_len(input logic nine_bit);
        frame_len = nine_bit ? uart_ctl_pkg::FRAME_LEN_9 : uart_ctl_pkg::FRAME_LEN_8;
    endfunction

    // Register decode
    wire wr_ctrl2 = i_wr && (i_addr == uart_ctl_pkg::CTRL2_OFS);
    wire wr_mode = i_wr && (i_addr == uart_ctl_pkg::MODE_OFS);
    wire wr_data = i_wr && (i_addr == uart_ctl_pkg::DATA_OFS);

    // Control fields
    wire tx_empty_irq_en = ctrl2_reg[uart_ctl_pkg::TX_EMPTY_IRQ_EN_BIT];
    wire tx_done_irq_en = ctrl2_reg[uart_ctl_pkg::TX_DONE_IRQ_EN_BIT];
    wire rx_full_irq_en = ctrl2_reg[uart_ctl_pkg::RX_FULL_IRQ_EN_BIT];
    wire line_quiet_irq_en = ctrl2_reg[uart_ctl_pkg::LINE_QUIET_IRQ_EN_BIT];
    wire transmitter_on = ctrl2_reg[uart_ctl_pkg::TRANSMITTER_ON_BIT];
    wire rx_on = ctrl2_reg[uart_ctl_pkg::RX_ON_BIT];
    wire rx_standby = ctrl2_reg[uart_ctl_pkg::RX_STANDBY_BIT];
    wire break_request = ctrl2_reg[uart_ctl_pkg::BREAK_REQUEST_BIT];
    wire long_break_select = mode_reg[uart_ctl_pkg::LONG_BREAK_BIT];
    wire nine_bit = mode_reg[uart_ctl_pkg::NINE_BIT_BIT];
    wire wake_method = mode_reg[uart_ctl_pkg::WAKE_METHOD_BIT];
    wire loopback_select = mode_reg[uart_ctl_pkg::LOOPBACK_BIT];
    wire rx_source_select = mode_reg[uart_ctl_pkg::RX_SOURCE_BIT];
    wire single_wire_direction = mode_reg[uart_ctl_pkg::DIRECTION_BIT];
    wire single_wire = loopback_select && rx_source_select;

    // Standby release: idle line or a character with its top data bit set
    wire wake_cond = wake_method ? (i_rx_char_done && i_rx_msb) : i_rx_idle_detect;
    wire wake_hit = rx_standby && wake_cond;
    wire [7:0] ctrl2_hw = wake_hit ? (ctrl2_reg & ~(8'h01 << uart_ctl_pkg::RX_STANDBY_BIT))
                                   : ctrl2_reg;
    // A software write wins over the automatic clear in the same cycle
    assign ctrl2_next = wr_ctrl2 ? i_wdata : ctrl2_hw;

    // Queue requests seen on rising edges of the written bits
    wire te_rise = wr_ctrl2 && i_wdata[uart_ctl_pkg::TRANSMITTER_ON_BIT] && !transmitter_on;
    wire brk_rise = wr_ctrl2 && i_wdata[uart_ctl_pkg::BREAK_REQUEST_BIT] && !break_request;

    // Shifter scheduling: break first, then idle, then buffered data
    logic sh_busy;
    logic sh_serial;
    wire sh_free = !sh_busy;
    // A held request reloads a break whenever the shifter frees with transmitter_on set; a short pulse may give two
    wire held_break = break_request && transmitter_on;
    wire start_break = sh_free && (break_pending_reg || held_break);
    wire start_idle = sh_free && !start_break && idle_pending_reg;
    // Buffered data waits for the transmitter; only queued idle and break drain when off
    wire start_data = sh_free && transmitter_on && !start_break && !idle_pending_reg
                      && !tx_empty_reg;
    wire sh_load = start_break || start_idle || start_data;
    wire [3:0] data_len = frame_len(nine_bit);
    wire [3:0] break_len = long_break_select ? 4'(data_len + uart_ctl_pkg::LONG_BREAK_EXTRA)
                                             : data_len;
    wire [14:0] data_frame = nine_bit ? {5'h1f, txbuf_reg, 1'b0} : {6'h3f, txbuf_reg[7:0], 1'b0};
    wire [14:0] sh_frame = start_break ? 15'h0000 : (start_idle ? 15'h7fff : data_frame);
    wire [3:0] sh_len = start_break ? break_len : data_len;

    // Activity that holds off the transmit-done flag, unsent buffered data included
    wire tx_pending = !tx_empty_reg || break_pending_reg || idle_pending_reg;
    wire tx_active = sh_busy || tx_pending || (break_request && transmitter_on);
    wire tx_done_flag = !tx_active;
    wire tx_buffer_empty_flag = tx_empty_reg;

    tx_frame_shifter u_shifter (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_bit_tick(i_bit_tick),
        .i_load(sh_load),
        .i_frame(sh_frame),
        .i_len(sh_len),
        .o_busy(sh_busy),
        .o_serial(sh_serial)
    );

    // Control and mode registers
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl2_reg <= uart_ctl_pkg::CTRL2_RESET;
            mode_reg <= uart_ctl_pkg::MODE_RESET;
        end else begin
            ctrl2_reg <= ctrl2_next;
            mode_reg <= wr_mode ? i_wdata : mode_reg;
        end
    end

    // Queued break and idle; a new request in the start cycle is kept
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            break_pending_reg <= 1'b0;
            idle_pending_reg <= 1'b0;
        end else begin
            break_pending_reg <= brk_rise || (break_pending_reg && !start_break);
            idle_pending_reg <= te_rise || (idle_pending_reg && !start_idle);
        end
    end

    // Transmit buffer; a write during the hand-off refills it at once
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            txbuf_reg <= 9'h000;
            tx_empty_reg <= 1'b1;
        end else begin
            if (wr_data) begin
                txbuf_reg <= {mode_reg[uart_ctl_pkg::TX_NINTH_BIT], i_wdata};
            end
            tx_empty_reg <= wr_data ? 1'b0 : (tx_empty_reg || start_data);
        end
    end

    // Pin synchronisers: two stages before anything looks at the pins
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            txd_meta_reg <= 1'b1;
            txd_sync_reg <= 1'b1;
            rxd_meta_reg <= 1'b1;
            rxd_sync_reg <= 1'b1;
        end else begin
            txd_meta_reg <= i_txd_pin;
            txd_sync_reg <= txd_meta_reg;
            rxd_meta_reg <= i_rxd_pin;
            rxd_sync_reg <= rxd_meta_reg;
        end
    end

    // Transmit pin ownership and direction
    // Unsent buffered data cannot keep the pin, or it would stay claimed for ever
    wire pin_claimed = transmitter_on || sh_busy || break_pending_reg
                       || idle_pending_reg;
    wire pin_outward = !single_wire || single_wire_direction;
    assign o_txd_oe = pin_claimed && pin_outward;
    assign o_txd_out = sh_serial;
    assign o_rxd_owned = rx_on && !loopback_select;

    // Receiver input select; single-wire hears its own line while driving
    wire rx_src_single = o_txd_oe ? sh_serial : txd_sync_reg;
    wire rx_src = loopback_select ? (rx_source_select ? rx_src_single : sh_serial)
                                  : rxd_sync_reg;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_serial_reg <= 1'b1;
        end else begin
            rx_serial_reg <= rx_src;
        end
    end
    assign o_rx_serial = rx_serial_reg;
    assign o_rx_standby = rx_standby;

    // Read mux; unmapped offsets and the data offset read zero
    wire [7:0] status_word = {tx_buffer_empty_flag, tx_done_flag, i_rx_full_flag,
                              i_line_quiet_flag, 4'h0};
    wire [7:0] rd_word = (i_addr == uart_ctl_pkg::CTRL2_OFS) ? ctrl2_reg :
                         (i_addr == uart_ctl_pkg::MODE_OFS) ? mode_reg :
                         (i_addr == uart_ctl_pkg::STATUS_OFS) ? status_word : 8'h00;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= i_rd ? rd_word : 8'h00;
        end
    end
    assign o_rdata = rdata_reg;

    // Level interrupt; drops only when every enabled flag has cleared
    wire irq_tx_empty = tx_empty_irq_en && tx_buffer_empty_flag;
    wire irq_tx_done = tx_done_irq_en && tx_done_flag;
    wire irq_rx_full = rx_full_irq_en && i_rx_full_flag;
    wire irq_quiet = line_quiet_irq_en && i_line_quiet_flag;
    assign o_irq = irq_tx_empty || irq_tx_done || irq_rx_full || irq_quiet;

    // Checks
    a_ctrl2_write: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        wr_ctrl2 |=> ctrl2_reg == $past(i_wdata))
        else $error("control register two did not take the write");
    a_ctrl2_read: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_rd && i_addr == uart_ctl_pkg::CTRL2_OFS) |=> o_rdata == $past(ctrl2_reg))
        else $error("control register two read back wrong");
    a_irq_tx_empty: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (ctrl2_reg[7] && tx_empty_reg) |-> o_irq)
        else $error("transmit empty interrupt missing");
    a_irq_tx_done: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (ctrl2_reg[6] && !sh_busy && !tx_pending && !break_request) |-> o_irq)
        else $error("transmit done interrupt missing");
    a_irq_rx_full: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (ctrl2_reg[5] && i_rx_full_flag) |-> o_irq)
        else $error("receive full interrupt missing");
    a_irq_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (ctrl2_reg[4] && i_line_quiet_flag) |-> o_irq)
        else $error("line quiet interrupt missing");
    a_irq_none: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (ctrl2_reg[7:4] == 4'h0) |-> !o_irq)
        else $error("interrupt raised with all enables off");
    a_te_drives_pin: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (transmitter_on && !single_wire) |-> o_txd_oe)
        else $error("transmit pin not driven while transmitter on");
    a_single_wire_in: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (single_wire && !single_wire_direction) |-> !o_txd_oe)
        else $error("single wire inbound yet pin driven");
    a_idle_queued: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        te_rise |=> idle_pending_reg ##1 (sh_busy || idle_pending_reg))
        else $error("idle character not queued");
    a_pin_held_off: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (!transmitter_on && sh_busy && !single_wire) |-> o_txd_oe)
        else $error("pin released with frame in flight");
    a_rx_pin_free: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (loopback_select || !rx_on) |-> !o_rxd_owned)
        else $error("receive pin kept while it should be released");
    a_wake_clear: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (wake_hit && !wr_ctrl2) |=> !rx_standby)
        else $error("standby not cleared on wakeup");
    a_break_zero: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        start_break |=> (!o_txd_out && sh_busy) [*2])
        else $error("break frame not low");
    a_buf_empty_set: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (start_data && !wr_data) |=> tx_empty_reg && sh_busy)
        else $error("buffer empty flag not set on hand-off");
    a_data_waits: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (!transmitter_on && !tx_empty_reg && sh_free && !break_pending_reg && !idle_pending_reg)
        |=> !sh_busy)
        else $error("data started with the transmitter off");
    a_pin_released: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (!transmitter_on && !sh_busy && !break_pending_reg && !idle_pending_reg && !wr_ctrl2)
        |=> !o_txd_oe)
        else $error("transmit pin kept after all work finished");
    a_break_repeat: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (sh_free && held_break) |=> (sh_busy && !o_txd_out))
        else $error("held break did not restart");
    a_loop_source: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (loopback_select && !rx_source_select) |=> o_rx_serial == $past(sh_serial))
        else $error("loopback receiver input not the transmitter");
endmodule
`default_nettype wire

// ===== tb/serial_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model (
    // Clock, reset and bit timing
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_bit_tick,
    // Line heard from the transmit pin
    input wire logic i_line,
    // What the far end has seen
    output logic [7:0] o_last_byte,
    output logic [15:0] o_n_bytes,
    output logic [15:0] o_n_breaks,
    output logic [15:0] o_last_zero_run
);
    logic [3:0] pos;
    logic [7:0] shreg;
    logic hunting;
    logic [15:0] run;

    // Samples once per bit time; a missing stop bit is a break, then waits for a mark
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pos <= 4'h0;
            shreg <= 8'h00;
            hunting <= 1'b0;
            run <= 16'h0000;
            o_last_byte <= 8'h00;
            o_n_bytes <= 16'h0000;
            o_n_breaks <= 16'h0000;
            o_last_zero_run <= 16'h0000;
        end else if (i_bit_tick) begin
            if (i_line) begin
                if (run != 16'h0000) o_last_zero_run <= run;
                run <= 16'h0000;
                hunting <= 1'b0;
            end else begin
                run <= run + 16'h0001;
            end
            if (!hunting) begin
                if (pos == 4'h0) begin
                    if (!i_line) pos <= 4'h1;
                end else if (pos < 4'h9) begin
                    shreg <= {i_line, shreg[7:1]}; // Least significant bit first
                    pos <= pos + 4'h1;
                end else begin
                    pos <= 4'h0;
                    if (i_line) begin
                        o_last_byte <= shreg;
                        o_n_bytes <= o_n_bytes + 16'h0001;
                    end else begin
                        o_n_breaks <= o_n_breaks + 16'h0001;
                        hunting <= 1'b1;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
    logic i_ref_clk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_bit_tick = 1'b0;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00, rdata, rd_val, last_byte;
    logic rx_full = 1'b0, quiet = 1'b0, idle_det = 1'b0, char_done = 1'b0, rx_msb = 1'b0;
    logic rxd_level = 1'b1, peer_en = 1'b0, peer_val = 1'b1;
    logic txd_out, txd_oe, rxd_owned, rx_serial, rx_standby, irq;
    logic [15:0] n_bytes, n_breaks, zero_run;
    wire logic txd_line;
    int mismatches = 0, n_tests = 0, tick_cnt = 0, k, m;

    always #10 i_ref_clk = ~i_ref_clk;
    // A bit time of four clocks keeps every frame short
    always @(posedge i_ref_clk) begin
        tick_cnt <= (tick_cnt + 1) % 4;
        i_bit_tick <= (tick_cnt == 3);
    end
    // Pulled-up line: the block, or the far end in single-wire tests, or nobody
    assign txd_line = txd_oe ? txd_out : (peer_en ? peer_val : 1'b1);

    uart_control_two_logic uart_control_two_logic_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
        .i_bit_tick(i_bit_tick), .i_rx_full_flag(rx_full), .i_line_quiet_flag(quiet),
        .i_rx_idle_detect(idle_det), .i_rx_char_done(char_done), .i_rx_msb(rx_msb),
        .i_txd_pin(txd_line), .o_txd_out(txd_out), .o_txd_oe(txd_oe), .i_rxd_pin(rxd_level),
        .o_rxd_owned(rxd_owned), .o_rx_serial(rx_serial), .o_rx_standby(rx_standby),
        .o_irq(irq));
    serial_peer_model serial_peer_model_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .i_bit_tick(i_bit_tick), .i_line(txd_line), .o_last_byte(last_byte),
        .o_n_bytes(n_bytes), .o_n_breaks(n_breaks), .o_last_zero_run(zero_run));

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 rd_val = rdata;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    // Polls the done flag; a hang ends the run rather than stalling it
    task automatic wait_done();
        for (k = 0; k < 400; k++) begin
            rd(3'h4);
            if (rd_val[6] === 1'b1) break;
        end
        if (k == 400) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, rd_val, 8'h40);
            stop_test();
        end
    endtask
    task automatic wake(input logic idle, input logic msb);
        @(posedge i_ref_clk);
        idle_det <= idle;
        char_done <= !idle;
        rx_msb <= msb;
        @(posedge i_ref_clk);
        idle_det <= 1'b0;
        char_done <= 1'b0;
        cycles(2);
    endtask

    initial begin
        repeat (20) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        rd(3'h3); `CHK(rd_val, 8'h00)
        rd(3'h4); `CHK(rd_val & 8'hc0, 8'hc0)
        `CHK(txd_oe, 1'b0)
        wr(3'h3, 8'hf6); rd(3'h3); `CHK(rd_val, 8'hf6)
        rd(3'h1); `CHK(rd_val, 8'h00)
        $display("test registers done");
        // Standby: idle wakeup, then address mark wakeup
        `CHK(rx_standby, 1'b1)
        wake(1'b1, 1'b0); `CHK(rx_standby, 1'b0)
        wr(3'h0, 8'h04); wr(3'h3, 8'h02);
        wake(1'b1, 1'b0); `CHK(rx_standby, 1'b1)
        wake(1'b0, 1'b0); `CHK(rx_standby, 1'b1)
        wake(1'b0, 1'b1); `CHK(rx_standby, 1'b0)
        rd(3'h3); `CHK(rd_val[1], 1'b0)
        wr(3'h0, 8'h00);
        $display("test standby done");
        // Every enable pattern against every receiver flag pattern; transmit flags are 1
        for (m = 0; m < 64; m++) begin
            wr(3'h3, {m[5:2], 4'h0});
            rx_full <= m[1];
            quiet <= m[0];
            cycles(2);
            `CHK(irq, m[5] | m[4] | (m[3] & m[1]) | (m[2] & m[0]))
        end
        rx_full <= 1'b0;
        quiet <= 1'b0;
        $display("test interrupts done");
        // Receive pin ownership and receiver source
        for (m = 0; m < 4; m++) begin
            wr(3'h0, {4'h0, m[1], 3'h0}); wr(3'h3, {5'h00, m[0], 2'h0});
            rxd_level <= 1'b0;
            cycles(6);
            `CHK(rxd_owned, m[0] & !m[1])
            if (m != 0) `CHK(rx_serial, m[1])
        end
        rxd_level <= 1'b1;
        wr(3'h0, 8'h18); wr(3'h3, 8'h08); cycles(2);
        `CHK(txd_oe, 1'b0)
        peer_en <= 1'b1; peer_val <= 1'b0; cycles(6);
        `CHK(rx_serial, 1'b0)
        wr(3'h0, 8'h38); cycles(2); `CHK(txd_oe, 1'b1)
        wait_done(); wr(3'h3, 8'h00); wr(3'h0, 8'h00); peer_en <= 1'b0; cycles(4);
        $display("test pins done");
        // Reset in mid-run also clears what the far end counted during the pin tests
        i_nrst <= 1'b0;
        cycles(2);
        i_nrst <= 1'b1;
        rd(3'h4); `CHK(rd_val & 8'hc0, 8'hc0)
        rd(3'h3); `CHK(rd_val, 8'h00)
        `CHK(n_bytes, 16'h0000)
        // Data waits for the transmitter; enabling it queues an idle first
        wr(3'h7, 8'h5a); cycles(60);
        `CHK(n_bytes, 16'h0000)
        `CHK(txd_oe, 1'b0)
        rd(3'h4); `CHK(rd_val[7], 1'b0)
        wr(3'h3, 8'h08); `CHK(txd_oe, 1'b1)
        rd(3'h4); `CHK(rd_val[6], 1'b0)
        wait_done(); `CHK(n_bytes, 16'h0001)
        `CHK(last_byte, 8'h5a)
        wr(3'h7, 8'hc3); cycles(12); wr(3'h3, 8'h00); wr(3'h3, 8'h08);
        for (k = 0; k < 300 && n_bytes !== 16'h0002; k++) cycles(1);
        `CHK(n_bytes, 16'h0002)
        rd(3'h4); `CHK(rd_val[6], 1'b0)
        wait_done();
        wr(3'h7, 8'h81); cycles(8); wr(3'h3, 8'h00); `CHK(txd_oe, 1'b1)
        wait_done(); cycles(2); `CHK(txd_oe, 1'b0)
        `CHK(last_byte, 8'h81)
        $display("test transmit done");
        // Short request gives one or two merged breaks; held long breaks repeat
        wr(3'h3, 8'h09); wr(3'h3, 8'h08); wait_done(); cycles(8);
        `CHK(n_breaks, 16'h0001)
        `CHK((zero_run == 16'd10) || (zero_run == 16'd20), 1'b1)
        wr(3'h0, 8'h01); wr(3'h3, 8'h09); cycles(156); wr(3'h3, 8'h08); wait_done(); cycles(8);
        `CHK((zero_run % 16'd13 == 16'd0) && (zero_run >= 16'd39), 1'b1)
        `CHK(n_breaks, 16'h0002)
        // Nine-bit format stretches a break to eleven bit times
        wr(3'h0, 8'h02); wr(3'h3, 8'h09); wr(3'h3, 8'h08); wait_done(); cycles(8);
        `CHK((zero_run == 16'd11) || (zero_run == 16'd22), 1'b1)
        `CHK(n_breaks, 16'h0003)
        wr(3'h0, 8'h00);
        $display("test breaks done");
        stop_test();
    end
endmodule
`default_nettype wire
